// ===== hdl/cp_addr_gen.sv
// Transfer address computation: start address and base write-back value
`timescale 1ns/1ps
module cp_addr_gen (
   // Operands
   input wire logic [31:0] base_i,
   input wire logic [31:0] offset_i,
   input wire logic offset_sub_i,
   input wire logic pre_index_i,
   // Results
   output logic [31:0] start_addr_o,
   output logic [31:0] new_base_o
);
   wire logic [31:0] indexed;
   assign indexed = offset_sub_i ? base_i - offset_i : base_i + offset_i;
   assign start_addr_o = pre_index_i ? indexed : base_i;
   assign new_base_o = indexed;
endmodule // cp_addr_gen

// ===== hdl/cp_xfer_pkg.sv
// Package: constants and types for the coprocessor data transfer sequencer
package cp_xfer_pkg;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;

   // Offsets from the instruction address, and the step between word addresses
   localparam logic [31:0] FETCH_OFFSET = 32'h0000_0008;
   localparam logic [31:0] RESUME_OFFSET = 32'h0000_000c;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;

   // Access size code for a word
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // Values after reset
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

   // Request from the instruction pipeline
   typedef struct packed {
      logic [31:0] pc;
      logic [31:0] base;
      logic [31:0] offset;
      logic offset_sub;
      logic pre_index;
      logic write_back;
      logic to_memory;
   } xfer_req_type;

   // Memory bus outputs
   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] size;
      logic write_not_read;
      logic mem_request_n;
      logic sequential_access;
      logic opcode_fetch_n;
   } mem_bus_type;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_ISSUE = 5'b00010,
      ST_WAIT = 5'b00100,
      ST_XFER = 5'b01000,
      ST_TRAP = 5'b10000
   } seq_state_type;

endpackage

// ===== hdl/cp_xfer_seq.sv
// Sequencer for coprocessor data transfers, both directions
//
// Summary of operation
// - Busy low starts issuing transfer addresses
// - One word per sequential memory cycle
// - First and wait cycles compute start address
// - Base write-back happens in the first transfer cycle
// - Stores sequence exactly like loads
// - Stores drive write-not-read high on transfers
// - Never issued in compressed instruction state
// - Wait cycles: pc+8, no request until busy drops, instr low
// - Instr high through transfers; last ends
// - Incrementing word addresses; sequential except last
// - First cycle drives pc+8 with instr low, requesting only if busy is already low
// - Then drive pc+8 on the address bus, requesting only in the cycle busy drops
// - Keep waiting while busy stays high
// - Absent and busy high means undefined trap
`timescale 1ns/1ps
module cp_xfer_seq (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   // Instruction request
   input wire logic start_i,
   input wire cp_xfer_pkg::xfer_req_type req_i,
   input wire logic compressed_instr_state_i,
   output logic busy_o,
   output logic done_o,
   output logic undef_trap_o,
   output logic rejected_o,
   // Base register write-back
   output logic wb_valid_o,
   output logic [31:0] wb_value_o,
   // Memory bus
   output cp_xfer_pkg::mem_bus_type mem_o,
   // Coprocessor handshake
   output logic coproc_instr_n_o,
   input wire logic coproc_absent_i,
   input wire logic coproc_busy_i,
   // Data words: load side gives memory data, store side takes it
   input wire logic [31:0] mem_rdata_i,
   input wire logic [31:0] coproc_data_word_i,
   output logic [31:0] coproc_data_word_o,
   output logic [31:0] mem_wdata_o
);

   cp_xfer_pkg::seq_state_type state_r, state_nxt;
   cp_xfer_pkg::xfer_req_type req_r;
   logic [31:0] xfer_addr_r;
   logic [31:0] xfer_addr_nxt;
   logic [31:0] rdata_r;
   logic [31:0] wdata_r;
   logic done_r;
   logic trap_r;
   logic wb_valid_r;
   logic [31:0] wb_value_r;

   wire logic [31:0] start_addr;
   wire logic [31:0] new_base;
   wire logic [31:0] fetch_addr;
   wire logic [31:0] resume_addr;
   wire logic in_idle;
   wire logic in_issue;
   wire logic in_wait;
   wire logic in_xfer;
   wire logic hs_commit;
   wire logic hs_absent;
   wire logic hs_last;
   wire logic accept;

   cp_addr_gen u_addr (
      .base_i(req_r.base),
      .offset_i(req_r.offset),
      .offset_sub_i(req_r.offset_sub),
      .pre_index_i(req_r.pre_index),
      .start_addr_o(start_addr),
      .new_base_o(new_base)
   );

   assign in_idle = (state_r == cp_xfer_pkg::ST_IDLE);
   assign in_issue = (state_r == cp_xfer_pkg::ST_ISSUE);
   assign in_wait = (state_r == cp_xfer_pkg::ST_WAIT);
   assign in_xfer = (state_r == cp_xfer_pkg::ST_XFER);

   assign fetch_addr = req_r.pc + cp_xfer_pkg::FETCH_OFFSET;
   assign resume_addr = req_r.pc + cp_xfer_pkg::RESUME_OFFSET;

   // Handshake decode on the coprocessor lines
   assign hs_commit = !coproc_absent_i && !coproc_busy_i;
   assign hs_absent = coproc_absent_i && coproc_busy_i;
   assign hs_last = coproc_absent_i && coproc_busy_i;

   // A start in compressed state is refused outright
   assign accept = start_i && in_idle && !compressed_instr_state_i;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         cp_xfer_pkg::ST_IDLE: begin
            if (accept) begin
               state_nxt = cp_xfer_pkg::ST_ISSUE;
            end
         end
         cp_xfer_pkg::ST_ISSUE, cp_xfer_pkg::ST_WAIT: begin
            // Absent low, busy high holds us here
            if (hs_commit) begin
               state_nxt = cp_xfer_pkg::ST_XFER;
            end else if (hs_absent) begin
               state_nxt = cp_xfer_pkg::ST_TRAP;
            end else begin
               state_nxt = cp_xfer_pkg::ST_WAIT;
            end
         end
         cp_xfer_pkg::ST_XFER: begin
            // Word count is whatever the coprocessor says
            if (hs_last) begin
               state_nxt = cp_xfer_pkg::ST_IDLE;
            end
         end
         cp_xfer_pkg::ST_TRAP: begin
            state_nxt = cp_xfer_pkg::ST_IDLE;
         end
      endcase
   end

   // Address steps one word per transfer cycle
   assign xfer_addr_nxt = ((in_issue || in_wait) ? start_addr
                           : xfer_addr_r + cp_xfer_pkg::WORD_STEP);

   // Memory bus drive: issue/wait at pc+8, transfers at xfer address
   always_comb begin
      mem_o.size = cp_xfer_pkg::SIZE_WORD;
      mem_o.addr = resume_addr;
      mem_o.write_not_read = 1'b0;
      mem_o.mem_request_n = 1'b0;
      mem_o.sequential_access = 1'b0;
      mem_o.opcode_fetch_n = 1'b1;
      coproc_instr_n_o = 1'b1;
      if (in_issue || in_wait) begin
         mem_o.addr = fetch_addr;
         mem_o.opcode_fetch_n = in_wait;
         coproc_instr_n_o = 1'b0;
         // Request only once busy drops in this cycle
         mem_o.mem_request_n = !hs_commit;
      end else if (in_xfer) begin
         mem_o.addr = xfer_addr_r;
         mem_o.write_not_read = req_r.to_memory;
         mem_o.sequential_access = !hs_last;
      end else if (in_idle || state_r == cp_xfer_pkg::ST_TRAP) begin
         // Trap entry fetches belong to the exception logic, not to us
         mem_o.mem_request_n = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= cp_xfer_pkg::ST_IDLE;
         req_r <= '0;
         xfer_addr_r <= cp_xfer_pkg::ADDR_RESET;
      end else if (clk_en_i) begin
         state_r <= state_nxt;
         if (accept) begin
            req_r <= req_i;
         end
         if (in_issue || in_wait || in_xfer) begin
            xfer_addr_r <= xfer_addr_nxt;
         end
      end
   end

   // Data words registered one per transfer cycle
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_r <= '0;
         wdata_r <= '0;
      end else if (clk_en_i && in_xfer) begin
         rdata_r <= mem_rdata_i;
         wdata_r <= coproc_data_word_i;
      end
   end

   // Coprocessor word passes straight to memory in its own cycle
   assign mem_wdata_o = in_xfer ? coproc_data_word_i : wdata_r;
   assign coproc_data_word_o = in_xfer ? mem_rdata_i : rdata_r;

   // Write-back lands during the first transfer cycle, not an extra one
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wb_valid_r <= 1'b0;
         wb_value_r <= '0;
         done_r <= 1'b0;
         trap_r <= 1'b0;
      end else if (clk_en_i) begin
         wb_valid_r <= (in_issue || in_wait) && hs_commit
                       && req_r.write_back;
         if ((in_issue || in_wait) && hs_commit) begin
            wb_value_r <= new_base;
         end
         done_r <= in_xfer && hs_last;
         trap_r <= (in_issue || in_wait) && hs_absent;
      end
   end

   assign wb_valid_o = wb_valid_r;
   assign wb_value_o = wb_value_r;
   assign done_o = done_r;
   assign undef_trap_o = trap_r;
   assign busy_o = !in_idle;
   assign rejected_o = start_i && in_idle && compressed_instr_state_i;

endmodule // cp_xfer_seq

// ===== testbench/cp_partner.sv
// Behavioural coprocessor answering the transfer handshake
`timescale 1ns/1ps
module cp_partner (
   input logic clk_i, instr_n_i, req_n_i, unable_i,
   input int waits_i, words_i,
   output logic absent_o, busy_o,
   output logic [31:0] word_o
);
   int wc = 0;
   int xc = 0;
   initial {absent_o, busy_o, word_o} = {2'h3, 32'h0};
   always @(negedge clk_i) begin
      if (!instr_n_i) begin
         absent_o <= unable_i;
         busy_o <= unable_i || wc < waits_i;
         wc <= wc + 1;
      end else if (!req_n_i) begin
         absent_o <= xc == words_i - 1;
         busy_o <= xc == words_i - 1;
         word_o <= 32'hc0de_0000 + xc;
         xc <= xc + 1;
      end else begin
         // Released: data line no longer holds the last word
         {absent_o, busy_o, wc, xc} <= {2'h3, 64'h0};
         word_o <= ~word_o;
      end
   end
endmodule // cp_partner

// ===== testbench/cp_xfer_props.sv
// Port assertions for the coprocessor transfer sequencer
`timescale 1ns/1ps
module cp_xfer_props (
   input logic clk_sys_i, sys_rst_i, clk_en_i,
   input logic start_i, compressed_instr_state_i,
   input cp_xfer_pkg::xfer_req_type req_i,
   input logic busy_o, done_o, undef_trap_o, rejected_o,
   input cp_xfer_pkg::mem_bus_type mem_o,
   input logic coproc_instr_n_o, coproc_absent_i, coproc_busy_i
);
   wire wt = !coproc_instr_n_o;
   wire xf = coproc_instr_n_o && !mem_o.mem_request_n;
   wire last = coproc_absent_i && coproc_busy_i;
   logic [31:0] fa_r;
   logic dir_r;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fa_r <= '0;
         dir_r <= 1'b0;
      end else begin
         if (wt) fa_r <= mem_o.addr;
         if (start_i && !busy_o) dir_r <= req_i.to_memory;
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_take;
      start_i && !busy_o && clk_en_i && !compressed_instr_state_i;
   endsequence
   sequence s_issue;
      wt && !mem_o.opcode_fetch_n;
   endsequence
   a_issue_fetch: assert property (s_take |=> s_issue ##0
      mem_o.addr == $past(req_i.pc) + cp_xfer_pkg::FETCH_OFFSET)
      else $error("issue cycle wrong");
   a_wait_hold: assert property (wt && $past(wt && clk_en_i)
      |-> $stable(mem_o.addr) && mem_o.opcode_fetch_n)
      else $error("wait cycle wrong");
   a_wait_idle: assert property (wt && coproc_busy_i
      |-> mem_o.mem_request_n) else $error("request during wait");
   a_commit_req: assert property (wt && !coproc_busy_i
      && !coproc_absent_i |-> !mem_o.mem_request_n)
      else $error("no request on commit");
   a_xfer_word: assert property (xf |-> mem_o.size == 2'h2
      && mem_o.write_not_read == dir_r
      && mem_o.sequential_access == !last) else $error("bad transfer");
   a_addr_step: assert property (xf && !coproc_busy_i && clk_en_i
      |=> xf && mem_o.addr == $past(mem_o.addr) + 32'h4)
      else $error("address not stepped");
   a_resume_addr: assert property (xf && last && clk_en_i |=> done_o
      && mem_o.mem_request_n && mem_o.addr == fa_r + 32'h4)
      else $error("no resume fetch");
   a_trap_taken: assert property (wt && last && clk_en_i
      |=> undef_trap_o && coproc_instr_n_o && mem_o.mem_request_n
      ##1 !busy_o) else $error("no trap");
   a_refuse_cmp: assert property (start_i && compressed_instr_state_i
      && !busy_o && clk_en_i |-> rejected_o ##1 !busy_o)
      else $error("start not refused");
endmodule // cp_xfer_props

// ===== testbench/tb_top.sv
// Self-checking bench for the coprocessor transfer sequencer
`timescale 1ns/1ps
module tb_top;
   logic clk_sys_i = 0, sys_rst_i = 1, start_i = 0, cmp = 0, unable = 0;
   logic busy, done, trap, rej, wbv, instr_n, absent, cbusy;
   logic [31:0] wbval, cdo, cdi, wdat, rdata = 0;
   cp_xfer_pkg::xfer_req_type req = '0;
   cp_xfer_pkg::mem_bus_type mem;
   int waits = 0, words = 1, err_count = 0, total_checks = 0;
   int seed = 21119, cyc = 0;
   cp_xfer_seq DUT (.clk_sys_i, .sys_rst_i, .clk_en_i(1'b1), .start_i,
      .req_i(req), .compressed_instr_state_i(cmp), .busy_o(busy),
      .done_o(done), .undef_trap_o(trap), .rejected_o(rej),
      .wb_valid_o(wbv), .wb_value_o(wbval), .mem_o(mem),
      .coproc_instr_n_o(instr_n), .coproc_absent_i(absent),
      .coproc_busy_i(cbusy), .mem_rdata_i(rdata),
      .coproc_data_word_i(cdi), .coproc_data_word_o(cdo),
      .mem_wdata_o(wdat));
   cp_partner cp (.clk_i(clk_sys_i), .instr_n_i(instr_n),
      .req_n_i(mem.mem_request_n), .unable_i(unable), .waits_i(waits),
      .words_i(words), .absent_o(absent), .busy_o(cbusy), .word_o(cdi));
   always #20 clk_sys_i = ~clk_sys_i;
   always @(negedge clk_sys_i) rdata <= $random(seed);
   task chk(input logic ok);
      total_checks++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t output mismatch", $time);
      end
   endtask
   task end_of_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_of_test;
      end
   end
   task run(input logic tm, input int w, n, input logic un);
      logic [31:0] sa, nb;
      @(negedge clk_sys_i);
      while (busy !== 1'b0) @(negedge clk_sys_i);
      req = {$random(seed), $random(seed), $random(seed), 3'h0, tm};
      req.pc[1:0] = 2'h0;
      req.offset = req.offset & 32'h3fc;
      {req.offset_sub, req.pre_index, req.write_back} = $random(seed);
      {waits, words, unable, start_i} = {w, n, un, 1'b1};
      nb = req.offset_sub ? req.base - req.offset : req.base + req.offset;
      sa = req.pre_index ? nb : req.base;
      @(negedge clk_sys_i) start_i = 0;
      for (int j = 0; j <= w; j++) begin
         if (j > 0) @(negedge clk_sys_i);
         #10;
         chk(mem.addr === req.pc + 32'h8 && instr_n === 1'b0
            && mem.opcode_fetch_n === (j > 0)
            && mem.mem_request_n === (un || j < w));
         if (un) break;
      end
      if (un) begin
         @(negedge clk_sys_i);
         #10 chk(trap === 1'b1);
      end else begin
         for (int j = 0; j < n; j++) begin
            @(negedge clk_sys_i);
            #10;
            chk(mem.addr === sa + 4 * j && mem.size === 2'h2
               && mem.write_not_read === tm && instr_n === 1'b1
               && mem.mem_request_n === 1'b0
               && mem.sequential_access === (j < n - 1)
               && (tm ? wdat === cdi : cdo === rdata));
            if (j == 0) chk(wbv === req.write_back &&
               (!req.write_back || wbval === nb));
         end
         @(negedge clk_sys_i);
         #10;
         chk(mem.addr === req.pc + 32'hc && done === 1'b1
            && mem.mem_request_n === 1'b1);
      end
      $display("test done: store %0d waits %0d words %0d", tm, w, n);
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      @(negedge clk_sys_i) sys_rst_i = 0;
      run(0, 0, 1, 0);
      run(1, 0, 1, 0);
      run(0, 3, 4, 0);
      run(1, 2, 3, 0);
      run(0, 0, 2, 1);
      repeat (8) run($random(seed), {$random(seed)} % 4,
         1 + {$random(seed)} % 5, 0);
      @(negedge clk_sys_i) {cmp, start_i} = 2'h3;
      #10 chk(rej === 1'b1);
      @(negedge clk_sys_i) {cmp, start_i} = 2'h0;
      #10 chk(busy === 1'b0);
      $display("test done: compressed state refused");
      end_of_test;
   end
endmodule // tb_top
bind cp_xfer_seq cp_xfer_props u_props (.clk_sys_i, .sys_rst_i, .clk_en_i,
   .start_i, .compressed_instr_state_i, .req_i, .busy_o, .done_o,
   .undef_trap_o, .rejected_o, .mem_o, .coproc_instr_n_o,
   .coproc_absent_i, .coproc_busy_i);
